// file: src/scx_pkg.sv
// Shared constants and carrier types of the exception and interrupt unit
package scx_pkg;
  // Register byte offsets on the APB port
  localparam logic [7:0] ADDR_MSW = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STK_LO = 8'h08;
  localparam logic [7:0] ADDR_STK_HI = 8'h0C;
  localparam logic [7:0] ADDR_CAUSE = 8'h10;
  localparam logic [7:0] ADDR_VBASE = 8'h14;
  localparam logic [7:0] ADDR_VER0 = 8'h18;
  localparam logic [7:0] ADDR_VER1 = 8'h1C;
  // Machine-state word bit masks
  localparam logic [31:0] MSW_IRQ_EN = 32'h0000_0002;
  localparam logic [31:0] MSW_BRK_ACT = 32'h0000_0008;
  localparam logic [31:0] MSW_ICACHE = 32'h0000_0020;
  localparam logic [31:0] MSW_DCACHE = 32'h0000_0080;
  localparam logic [31:0] MSW_EXC_EN = 32'h0000_0100;
  localparam logic [31:0] MSW_EXC_ACT = 32'h0000_0200;
  localparam logic [31:0] MSW_IMPL = 32'h0000_03AA;
  // Vector offsets from the vector base; base low bits forced clear
  localparam logic [31:0] VEC_ALIGN_MASK = 32'hFFFF_FF80;
  localparam logic [31:0] VEC_IRQ_OFF = 32'h0000_0010;
  localparam logic [31:0] VEC_EXC_OFF = 32'h0000_0020;
  // Divide overflow operands and version field layout
  localparam logic [31:0] DIV_MIN_NEG = 32'h8000_0000;
  localparam logic [31:0] DIV_MINUS_ONE = 32'hFFFF_FFFF;
  localparam logic [31:0] NULL_WORD = 32'h0000_0000;
  localparam int TAG_LSB = 24;
  localparam logic [1:0] VER_NONE = 2'h0;
  localparam logic [1:0] VER_BASIC = 2'h1;
  localparam logic [1:0] VER_FULL = 2'h2;
  localparam logic [1:0] IRQ_OFF = 2'h0;
  localparam logic [1:0] IRQ_FAST = 2'h2;
  // Exception cause codes
  localparam logic [3:0] CAUSE_NONE = 4'h0;
  localparam logic [3:0] CAUSE_IBUS = 4'h1;
  localparam logic [3:0] CAUSE_ILLEGAL = 4'h2;
  localparam logic [3:0] CAUSE_DBUS = 4'h3;
  localparam logic [3:0] CAUSE_STACK = 4'h4;
  localparam logic [3:0] CAUSE_DIV = 4'h5;
  localparam logic [3:0] CAUSE_FPU = 4'h6;
  localparam logic [3:0] CAUSE_STREAM = 4'h7;

  // Software configuration word, bits 11..0
  typedef struct packed {
    logic [1:0] irq_use;
    logic edge_polarity_sel;
    logic edge_mode_sel;
    logic stack_prot_en;
    logic stream_exc_en;
    logic null_opcode_trap;
    logic ill_exc_en;
    logic dbus_exc_en;
    logic ibus_exc_en;
    logic div_exc_en;
    logic fpu_exc_en;
  } scx_cfg_t;
  localparam int CFG_W = 12;

  // Floating point flags from the FPU
  typedef struct packed {
    logic valid;
    logic underflow;
    logic overflow;
    logic div_zero;
    logic invalid;
    logic denorm;
  } scx_fpu_t;

  // Divide request operands
  typedef struct packed {
    logic valid;
    logic is_signed;
    logic [31:0] dividend;
    logic [31:0] divisor;
  } scx_div_t;

  // Bus response report, AXI resp encoding
  typedef struct packed {
    logic valid;
    logic [1:0] resp;
  } scx_resp_t;

  // Stack-addressed memory access
  typedef struct packed {
    logic valid;
    logic via_sp;
    logic [31:0] addr;
  } scx_stk_t;

  // Whole state of the unit
  typedef struct packed {
    logic [31:0] msw;
    scx_cfg_t cfg;
    logic [31:0] stk_lo;
    logic [31:0] stk_hi;
    logic [3:0] cause;
    logic irq_s1;
    logic irq_s2;
    logic irq_prev;
    logic pending;
    logic irq_req;
    logic irq_fast;
    logic exc_taken;
    logic [31:0] exc_vector;
    logic [31:0] prdata;
    logic pslverr;
    logic pready;
  } scx_state_t;
endpackage

// file: src/scx_unit.sv
// Exception, interrupt, reset-state and version logic with APB registers
`timescale 1ns/1ps
// Functional notes
// - FPU flags and denormal operand raise exception
// - Divide by zero or signed overflow traps
// - Instruction bus error response takes exception
// - Data bus error response takes exception
// - Invalid major opcode traps as illegal
// - Null word traps if enabled, else no-op
// - Stream read errors trap, needs stream instructions
// - Stack-pointer access outside bounds traps if MSW_EXC_EN set
// - Edge mode senses only selected transition
// - Level mode senses input while high
// - Held-high level input re-enters after handling
// - Polarity picks rising or falling edge
// - Interrupt unused, or usable as normal or fast
// - Cache enable bits selectable at reset
// - Break, irq, exception bits selectable at reset
// - Vector base relocates vectors, low 7 clear
// - Version option none, basic or full
// - Custom tag byte in bits 31..24
// - Custom tag word forms second version word
module scx_unit import scx_pkg::*; #(
  parameter logic [31:0] MSW_RESET = 32'h0000_0000,
  parameter logic [CFG_W-1:0] CFG_RESET = 12'h000,
  parameter logic [31:0] VECTOR_BASE = 32'h0000_0000,
  parameter logic [1:0] VERSION_OPTION = 2'h0,
  parameter logic [7:0] CUSTOM_TAG_BYTE = 8'h00,
  parameter logic [31:0] CUSTOM_TAG_WORD = 32'h0000_0000,
  parameter logic [63:0] OPCODE_VALID = 64'hFFFF_FFFF_FFFF_FFFF,
  parameter bit STREAM_INSNS = 1'b1
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire scx_fpu_t fpu_in,
  input wire scx_div_t div_in,
  input wire scx_resp_t ibus_in,
  input wire scx_resp_t dbus_in,
  input wire logic instr_valid_in,
  input wire logic [31:0] instr_word_in,
  input wire logic stream_err_in,
  input wire scx_stk_t stk_in,
  input wire logic irq_pin_in,
  input wire logic irq_ack_in,
  output logic irq_req_out,
  output logic irq_fast_out,
  output logic exc_taken_out,
  output logic [31:0] exc_vector_out,
  output logic [3:0] exc_cause_out,
  output logic [31:0] msw_out
);
  // Base is forced aligned so a stray low bit cannot split vectors
  localparam logic [31:0] VBASE = VECTOR_BASE & VEC_ALIGN_MASK;

  scx_state_t state_reg;
  scx_state_t state_next;

  logic hit_fpu, hit_div, hit_ibus, hit_dbus, hit_ill, hit_null;
  logic hit_stream, hit_stack, edge_seen, irq_gate;
  logic [31:0] ver0, ver1;

  // Exception source detection
  assign hit_fpu = state_reg.cfg.fpu_exc_en && fpu_in.valid &&
    (fpu_in.underflow || fpu_in.overflow || fpu_in.div_zero ||
     fpu_in.invalid || fpu_in.denorm);
  assign hit_div = state_reg.cfg.div_exc_en && div_in.valid &&
    (div_in.divisor == 32'h0000_0000 ||
     (div_in.is_signed && div_in.dividend == DIV_MIN_NEG &&
      div_in.divisor == DIV_MINUS_ONE));
  // Resp values SLVERR and DECERR both have the upper bit set
  assign hit_ibus = state_reg.cfg.ibus_exc_en && ibus_in.valid && ibus_in.resp[1];
  assign hit_dbus = state_reg.cfg.dbus_exc_en && dbus_in.valid && dbus_in.resp[1];
  // Null trap needs illegal traps on too; otherwise null runs as a no-op
  assign hit_null = instr_valid_in && instr_word_in == NULL_WORD &&
    state_reg.cfg.ill_exc_en && state_reg.cfg.null_opcode_trap;
  assign hit_ill = hit_null || (state_reg.cfg.ill_exc_en && instr_valid_in &&
    instr_word_in != NULL_WORD && !OPCODE_VALID[instr_word_in[31:26]]);
  assign hit_stream = STREAM_INSNS && state_reg.cfg.stream_exc_en && stream_err_in;
  assign hit_stack = state_reg.cfg.stack_prot_en && stk_in.valid && stk_in.via_sp &&
    (state_reg.msw & MSW_EXC_EN) != 32'h0000_0000 &&
    (stk_in.addr < state_reg.stk_lo || stk_in.addr > state_reg.stk_hi);

  // Edge detection works only on synchronised samples
  assign edge_seen = state_reg.cfg.edge_polarity_sel ?
    (state_reg.irq_s2 && !state_reg.irq_prev) :
    (!state_reg.irq_s2 && state_reg.irq_prev);
  assign irq_gate = state_reg.cfg.irq_use != IRQ_OFF &&
    (state_reg.msw & MSW_IRQ_EN) != 32'h0000_0000 &&
    (state_reg.msw & (MSW_EXC_ACT | MSW_BRK_ACT)) == 32'h0000_0000;

  // Version words; none reads as zero everywhere
  assign ver0 = (VERSION_OPTION == VER_BASIC || VERSION_OPTION == VER_FULL) ?
    {CUSTOM_TAG_BYTE, 24'h00_0000} : 32'h0000_0000;
  assign ver1 = (VERSION_OPTION == VER_FULL) ? CUSTOM_TAG_WORD : 32'h0000_0000;

  // Next-state logic for the whole unit
  always_comb begin
    logic any_hit;
    logic [3:0] cause_v;
    logic wr;
    logic [31:0] rdv;
    logic err;
    any_hit = 1'b0;
    cause_v = CAUSE_NONE;
    wr = psel_in && penable_in && pwrite_in;
    rdv = 32'h0000_0000;
    err = 1'b0;
    state_next = state_reg;
    // Two-flop synchroniser, then a history flop for edges
    state_next.irq_s1 = irq_pin_in;
    state_next.irq_s2 = state_reg.irq_s1;
    state_next.irq_prev = state_reg.irq_s2;
    // Fixed priority: fetch faults first, asynchronous-ish stream last
    if (hit_ibus) begin
      cause_v = CAUSE_IBUS;
    end else if (hit_ill) begin
      cause_v = CAUSE_ILLEGAL;
    end else if (hit_dbus) begin
      cause_v = CAUSE_DBUS;
    end else if (hit_stack) begin
      cause_v = CAUSE_STACK;
    end else if (hit_div) begin
      cause_v = CAUSE_DIV;
    end else if (hit_fpu) begin
      cause_v = CAUSE_FPU;
    end else if (hit_stream) begin
      cause_v = CAUSE_STREAM;
    end
    any_hit = cause_v != CAUSE_NONE;
    // Register writes take effect at the access edge
    if (wr) begin
      case (paddr_in)
        ADDR_MSW: state_next.msw = pwdata_in & MSW_IMPL;
        ADDR_CFG: state_next.cfg = scx_cfg_t'(pwdata_in[CFG_W-1:0]);
        ADDR_STK_LO: state_next.stk_lo = pwdata_in;
        ADDR_STK_HI: state_next.stk_hi = pwdata_in;
        default: state_next.msw = state_reg.msw;
      endcase
    end
    // Exception entry wins over a software write in the same cycle
    state_next.exc_taken = any_hit;
    if (any_hit) begin
      state_next.cause = cause_v;
      state_next.msw = state_next.msw | MSW_EXC_ACT;
      state_next.exc_vector = VBASE + VEC_EXC_OFF;
    end
    // Interrupt sensing; an edge set beats a same-cycle acknowledge
    if (state_reg.cfg.edge_mode_sel) begin
      state_next.pending = edge_seen || (state_reg.pending && !irq_ack_in);
    end else begin
      state_next.pending = state_reg.irq_s2;
    end
    state_next.irq_req = state_reg.pending && irq_gate && !any_hit;
    state_next.irq_fast = state_reg.pending && irq_gate && !any_hit &&
      state_reg.cfg.irq_use == IRQ_FAST;
    // Read data prepared in the setup phase so access needs no wait
    case (paddr_in)
      ADDR_MSW: rdv = state_reg.msw;
      ADDR_CFG: rdv = {{(32-CFG_W){1'b0}}, state_reg.cfg};
      ADDR_STK_LO: rdv = state_reg.stk_lo;
      ADDR_STK_HI: rdv = state_reg.stk_hi;
      ADDR_CAUSE: rdv = {28'h000_0000, state_reg.cause};
      ADDR_VBASE: rdv = VBASE;
      ADDR_VER0: rdv = ver0;
      ADDR_VER1: rdv = ver1;
      default: err = 1'b1;
    endcase
    // Read-only words reject writes with an error
    if (pwrite_in && (paddr_in == ADDR_CAUSE || paddr_in == ADDR_VBASE ||
        paddr_in == ADDR_VER0 || paddr_in == ADDR_VER1)) begin
      err = 1'b1;
    end
    if (psel_in && !penable_in) begin
      state_next.prdata = pwrite_in ? 32'h0000_0000 : rdv;
      state_next.pslverr = err;
    end
    state_next.pready = 1'b1;
  end

  // Single state register; reset loads selected machine-state bits
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
      state_reg.msw <= MSW_RESET & MSW_IMPL;
      state_reg.cfg <= scx_cfg_t'(CFG_RESET);
      state_reg.stk_hi <= 32'hFFFF_FFFF;
      state_reg.pready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from state flops
  assign prdata_out = state_reg.prdata;
  assign pready_out = state_reg.pready;
  assign pslverr_out = state_reg.pslverr;
  assign irq_req_out = state_reg.irq_req;
  assign irq_fast_out = state_reg.irq_fast;
  assign exc_taken_out = state_reg.exc_taken;
  assign exc_vector_out = state_reg.exc_vector;
  assign exc_cause_out = state_reg.cause;
  assign msw_out = state_reg.msw;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_ibus_err;
    state_reg.cfg.ibus_exc_en && ibus_in.valid && ibus_in.resp[1];
  endsequence
  sequence s_trap_ibus;
    exc_taken_out && exc_cause_out == CAUSE_IBUS;
  endsequence
  sequence s_stack_only;
    hit_stack && !hit_ibus && !hit_ill && !hit_dbus;
  endsequence

  a_exc_vector_base: assert property (exc_taken_out |->
    exc_vector_out == VBASE + VEC_EXC_OFF && (msw_out & MSW_EXC_ACT) != 32'h0)
    else $error("exception vector or active flag wrong");
  a_ibus_err_trap: assert property (s_ibus_err |=> s_trap_ibus)
    else $error("instruction bus error not trapped");
  a_dbus_err_trap: assert property (hit_dbus && !hit_ibus && !hit_ill |=>
    exc_taken_out && exc_cause_out == CAUSE_DBUS)
    else $error("data bus error not trapped");
  a_null_is_nop: assert property (instr_valid_in && instr_word_in == NULL_WORD &&
    !(state_reg.cfg.ill_exc_en && state_reg.cfg.null_opcode_trap) && !hit_ibus &&
    !hit_dbus && !hit_stack && !hit_div && !hit_fpu && !hit_stream |=> !exc_taken_out)
    else $error("null word trapped while trap is off");
  a_stack_bound_trap: assert property (s_stack_only |=>
    exc_taken_out && exc_cause_out == CAUSE_STACK)
    else $error("stack bound violation missed");
  a_level_retrigger: assert property (!state_reg.cfg.edge_mode_sel &&
    state_reg.irq_s2 && $stable(state_reg.cfg) ##1 irq_gate && !$past(irq_ack_in) &&
    state_reg.irq_s2 && !hit_ibus && !hit_ill && !hit_dbus && !hit_stack &&
    !hit_div && !hit_fpu && !hit_stream |=> irq_req_out)
    else $error("level interrupt not raised");
  a_edge_wrong_pol: assert property (state_reg.cfg.edge_mode_sel &&
    state_reg.cfg.edge_polarity_sel && !state_reg.pending &&
    state_reg.irq_prev && !state_reg.irq_s2 |=> !state_reg.pending)
    else $error("falling edge sensed in rising mode");
  a_irq_none_quiet: assert property (state_reg.cfg.irq_use == IRQ_OFF |=>
    !irq_req_out && !irq_fast_out)
    else $error("interrupt raised while unused");
  a_version_word1: assert property (psel_in && !penable_in && !pwrite_in &&
    paddr_in == ADDR_VER1 |=>
    prdata_out == ((VERSION_OPTION == VER_FULL) ? CUSTOM_TAG_WORD : 32'h0000_0000))
    else $error("second version word wrong");
  a_div_zero_trap: assert property (hit_div && !hit_ibus && !hit_ill && !hit_dbus &&
    !hit_stack |=> exc_taken_out && exc_cause_out == CAUSE_DIV)
    else $error("divide fault not trapped");
endmodule

// file: verif/scx_far_end.sv
// Far-side model: external interrupt source and two bus slaves
`timescale 1ns/1ps
module scx_far_end import scx_pkg::*; (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [1:0] line_cmd_in,
  input wire logic drop_on_ack_in,
  input wire logic irq_ack_in,
  input wire logic [1:0] bus_req_in,
  input wire logic [1:0] bus_resp_in,
  output logic irq_pin_out,
  output scx_resp_t ibus_out,
  output scx_resp_t dbus_out
);
  // Source line: 1 raises, 2 lowers; a polite source lets go on ack
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_pin_out <= 1'b0;
    end else if (line_cmd_in == 2'h1) begin
      irq_pin_out <= 1'b1;
    end else if (line_cmd_in == 2'h2 || (irq_ack_in && drop_on_ack_in)) begin
      irq_pin_out <= 1'b0;
    end
  end
  // One reply per request; idle code inverts so a stale code never looks valid
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ibus_out <= '0;
      dbus_out <= '0;
    end else begin
      ibus_out <= {bus_req_in[0], bus_req_in[0] ? bus_resp_in : ~ibus_out.resp};
      dbus_out <= {bus_req_in[1], bus_req_in[1] ? bus_resp_in : ~dbus_out.resp};
    end
  end
endmodule

// file: verif/scx_unit_test.sv
// Self-checking bench of the exception and interrupt unit
`timescale 1ns/1ps
module scx_unit_test import scx_pkg::*;;
  localparam logic [31:0] VB = 32'h0001_23C5;
  localparam logic [31:0] EXPV = (VB & VEC_ALIGN_MASK) + VEC_EXC_OFF;
  localparam logic [7:0] TAG_B = 8'h5A;
  localparam logic [31:0] TAG_W = 32'h1234_ABCD;
  logic clock_in, resetn, psel, penable, pwrite, e, iv, strm, ack, drop, seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, r, iw, wd;
  logic [1:0] line_cmd, breq, bresp;
  scx_fpu_t fpu;
  scx_div_t div;
  scx_stk_t stk;
  scx_resp_t ibus, dbus;
  wire logic irq_pin;
  logic [31:0] prdata_out, exc_vector_out, msw_out;
  logic pready_out, pslverr_out, irq_req_out, irq_fast_out, exc_taken_out;
  logic [3:0] exc_cause_out;
  int seed, mismatches, cmp_count, cyc, k;
  scx_unit #(.MSW_RESET(32'hFFFF_FFFF), .CFG_RESET(12'h000), .VECTOR_BASE(VB),
    .VERSION_OPTION(VER_FULL), .CUSTOM_TAG_BYTE(TAG_B), .CUSTOM_TAG_WORD(TAG_W),
    .OPCODE_VALID(64'h7FFF_FFFF_FFFF_FFFF), .STREAM_INSNS(1'b1)) u_scx_unit (
    .clock_in(clock_in), .resetn_in(resetn), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .fpu_in(fpu), .div_in(div),
    .ibus_in(ibus), .dbus_in(dbus), .instr_valid_in(iv), .instr_word_in(iw),
    .stream_err_in(strm), .stk_in(stk), .irq_pin_in(irq_pin), .irq_ack_in(ack),
    .irq_req_out(irq_req_out), .irq_fast_out(irq_fast_out), .exc_taken_out(exc_taken_out),
    .exc_vector_out(exc_vector_out), .exc_cause_out(exc_cause_out), .msw_out(msw_out));
  scx_far_end u_scx_far_end (.clock_in(clock_in), .resetn_in(resetn), .line_cmd_in(line_cmd),
    .drop_on_ack_in(drop), .irq_ack_in(ack), .bus_req_in(breq), .bus_resp_in(bresp),
    .irq_pin_out(irq_pin), .ibus_out(ibus), .dbus_out(dbus));
  // 25 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Setup, then access held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready_out !== 1'b1);
    r = prdata_out;
    e = pslverr_out;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask
  function automatic logic [3:0] cause_of(input int n);
    case (n)
      0: return CAUSE_IBUS;
      1, 12: return CAUSE_ILLEGAL;
      2: return CAUSE_DBUS;
      3: return CAUSE_STACK;
      4, 5: return CAUSE_DIV;
      11: return CAUSE_STREAM;
      default: return CAUSE_FPU;
    endcase
  endfunction
  // One-cycle event of kind n; 13 and 14 are legal operations
  task fire(input int n);
    @(posedge clock_in);
    case (n)
      0: begin breq <= 2'h1; bresp <= 2'h2; end
      1: begin iv <= 1'b1; iw <= 32'hFC00_0000; end
      2: begin breq <= 2'h2; bresp <= 2'h3; end
      3: stk <= {1'b1, 1'b1, 32'h0000_1001};
      4: div <= {1'b1, 1'b0, 32'h0000_0007, 32'h0};
      5: div <= {1'b1, 1'b1, DIV_MIN_NEG, DIV_MINUS_ONE};
      11: strm <= 1'b1;
      12: begin iv <= 1'b1; iw <= NULL_WORD; end
      13: stk <= {1'b1, 1'b1, 32'h0000_1000};
      14: begin div <= {1'b1, 1'b0, 32'($random(seed)), 32'($random(seed)) | 32'h1};
        breq <= 2'h1; bresp <= 2'($random(seed)) & 2'h1; end
      default: fpu <= {1'b1, 5'(5'h10 >> (n - 6))};
    endcase
    @(posedge clock_in);
    breq <= 2'h0; fpu <= '0; div <= '0; iv <= 1'b0; strm <= 1'b0; stk <= '0;
  endtask
  task expect_exc(input int n, input logic hit);
    seen = 1'b0;
    fire(n);
    repeat (3) begin
      @(negedge clock_in);
      seen = seen | (exc_taken_out === 1'b1);
    end
    chk({31'h0, seen}, {31'h0, hit});
    if (hit) chk({28'h0, exc_cause_out}, {28'h0, cause_of(n)});
    if (hit) chk(exc_vector_out, EXPV);
  endtask
  task watch;
    seen = 1'b0;
    repeat (8) begin
      @(negedge clock_in);
      seen = seen | (irq_req_out === 1'b1);
    end
  endtask
  // Line command for one cycle, then watch for a request
  task line_watch(input logic [1:0] c);
    @(posedge clock_in);
    line_cmd <= c;
    @(posedge clock_in);
    line_cmd <= 2'h0;
    watch;
  endtask
  task pulse_ack;
    @(posedge clock_in);
    ack <= 1'b1;
    @(posedge clock_in);
    ack <= 1'b0;
  endtask
  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; iv = 1'b0; iw = 32'h0; strm = 1'b0; ack = 1'b0; drop = 1'b0;
    line_cmd = 2'h0; breq = 2'h0; bresp = 2'h0; fpu = '0; div = '0; stk = '0;
    seed = 43; mismatches = 0; cmp_count = 0; cyc = 0;
    repeat (4) @(posedge clock_in);
    resetn <= 1'b1;
    @(negedge clock_in);
    chk(msw_out, MSW_IMPL);
    rd(ADDR_VER0, {TAG_B, 24'h0});
    rd(ADDR_VER1, TAG_W);
    rd(ADDR_STK_HI, 32'hFFFF_FFFF);
    rd(ADDR_VBASE, VB & VEC_ALIGN_MASK);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, ADDR_VER1, 32'h0);
    chk({31'h0, e}, 32'h1);
    rd(ADDR_VER1, TAG_W);
    // Random machine-state words; only implemented bits stick
    repeat (8) begin
      wd = $random(seed);
      apb(1'b1, ADDR_MSW, wd);
      rd(ADDR_MSW, wd & MSW_IMPL);
    end
    apb(1'b1, ADDR_MSW, 32'h0000_01A2);
    apb(1'b1, ADDR_STK_HI, 32'h0000_1000);
    apb(1'b1, ADDR_CFG, 32'h0000_00FF);
    rd(ADDR_CFG, 32'h0000_00FF);
    for (k = 0; k < 13; k++) expect_exc(k, 1'b1);
    chk(msw_out & MSW_EXC_ACT, MSW_EXC_ACT);
    rd(ADDR_CAUSE, {28'h0, CAUSE_ILLEGAL});
    expect_exc(13, 1'b0);
    repeat (10) expect_exc(14, 1'b0);
    // Float source and null trap off
    apb(1'b1, ADDR_CFG, 32'h0000_00DE);
    expect_exc(12, 1'b0);
    expect_exc(7, 1'b0);
    apb(1'b1, ADDR_MSW, 32'h0000_01A2);
    // Level, normal use
    apb(1'b1, ADDR_CFG, 32'h0000_0400);
    line_watch(2'h1);
    chk({31'h0, seen}, 32'h1);
    pulse_ack;
    watch;
    chk({31'h0, seen}, 32'h1);
    drop <= 1'b1;
    pulse_ack;
    repeat (8) @(negedge clock_in);
    chk({31'h0, irq_req_out}, 32'h0);
    drop <= 1'b0;
    // Rising edge, normal use: one request per edge, falling edge ignored
    apb(1'b1, ADDR_CFG, 32'h0000_0700);
    line_watch(2'h1);
    chk({31'h0, seen}, 32'h1);
    chk({31'h0, irq_fast_out}, 32'h0);
    pulse_ack;
    repeat (8) @(negedge clock_in);
    chk({31'h0, irq_req_out}, 32'h0);
    line_watch(2'h2);
    chk({31'h0, seen}, 32'h0);
    // Falling edge selected; a rising edge is ignored
    apb(1'b1, ADDR_CFG, 32'h0000_0500);
    line_watch(2'h1);
    chk({31'h0, seen}, 32'h0);
    line_watch(2'h2);
    chk({31'h0, seen}, 32'h1);
    pulse_ack;
    // Rising edge, fast use
    apb(1'b1, ADDR_CFG, 32'h0000_0B00);
    line_watch(2'h1);
    chk({31'h0, irq_fast_out}, 32'h1);
    pulse_ack;
    // Mid-run reset: state falls back to its reset values
    @(posedge clock_in);
    resetn <= 1'b0;
    repeat (2) @(posedge clock_in);
    resetn <= 1'b1;
    @(negedge clock_in);
    chk(msw_out, MSW_IMPL);
    chk(exc_vector_out, 32'h0000_0000);
    chk({31'h0, irq_req_out}, 32'h0);
    // Interrupt input unused: a raised level is ignored
    apb(1'b1, ADDR_CFG, 32'h0000_0000);
    line_watch(2'h1);
    chk({31'h0, seen}, 32'h0);
    report_and_stop;
  end
endmodule
